/* File: shared/tws_pkg.sv */
// Shared constants and types for the two-wire serial memory slave
package tws_pkg;

    // ----------------------------------------------------------------
    // Array geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 13; // Location address width
    localparam int PAGE_W = 5; // Byte offset within a page
    localparam int PAGE_BYTES = 32; // Bytes in one page
    localparam int HI_USED_W = 5; // Used bits of the first address byte

    // ----------------------------------------------------------------
    // Slave address layout
    // ----------------------------------------------------------------
    localparam int TYPE_MSB = 7; // Device type field top bit
    localparam int TYPE_LSB = 4; // Device type field low bit
    localparam int SEL_MSB = 3; // Selection field top bit
    localparam int SEL_LSB = 1; // Selection field low bit
    localparam int DIR_BIT = 0; // Direction bit, one means read

    // ----------------------------------------------------------------
    // Bit counter marks within a byte frame
    // ----------------------------------------------------------------
    localparam logic [3:0] BITS_DATA = 4'h8; // Eight data bits seen
    localparam logic [3:0] BITS_ACK = 4'h9; // Ninth clock seen

    // ----------------------------------------------------------------
    // Reset values and fill values
    // ----------------------------------------------------------------
    localparam logic [7:0] IDLE_BYTE = 8'hff; // Sent when no data is ready
    localparam logic [12:0] ADDR_RST = 13'h0000; // Address counter at reset

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000; // Core clock rate
    localparam int TWR_MS = 6; // Longest programming time, ms
    localparam int TWR_CYC = TWR_MS * (CLK_HZ / 1000); // Rounded down

    // ----------------------------------------------------------------
    // Transaction states, Gray along the write path
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        TWS_IDLE = 3'h0,
        TWS_DEV = 3'h1,
        TWS_AHI = 3'h3,
        TWS_ALO = 3'h2,
        TWS_WR = 3'h6,
        TWS_RD = 3'h7,
        TWS_IGN = 3'h5
    } tws_state_t;

endpackage

/* File: rtl/tws_slave.sv */
// Two-wire serial memory slave: protocol engine, page buffer and array
`timescale 1ns/1ps
// Summary of operation
// RL1 - Selected only when the 3-bit selection field equals the strap pins.
// RL2 - Master starts every transfer and drives the clock; we never drive it.
// RL3 - Data changes only while the clock is low; high-phase edges are conditions.
// RL4 - Ignore the bus until a start: data falling with the clock high.
// RL5 - Data rising with the clock high is a stop; return to standby.
// RL6 - Location is low five bits of first address byte plus second byte.
// RL7 - Byte write: address, two location bytes, one data byte, each acknowledged.
// RL8 - Stop after a write starts programming; no response until it ends.
// RL9 - Array is 32-byte aligned pages; one write programs up to one page.
// RL10 - Page write counter wraps inside its page, never into the next.
// RL11 - A page write may begin at any byte of the page.
// RL12 - Acknowledge and increment per data byte; extra bytes overwrite earlier ones.
// RL13 - Polling: no acknowledge while programming, acknowledge once done.
// RL14 - Write protect: acknowledge addresses, refuse first data byte, no programming.
// RL15 - Master starts reads with start and slave address with direction one.
// RL16 - Address counter holds last accessed location plus one, reads and writes.
// RL17 - Current read: acknowledge address, send eight bits, master nacks and stops.
// RL18 - Random read: dummy write of address, then repeated start and read.
// RL19 - Sequential read: next byte on each master acknowledge, until nack or stop.
// RL20 - Read counter uses all address bits and wraps from top to zero.
// RL21 - Receiver pulls data low on the ninth clock; transmitter releases it.
// RL22 - Last slave address bit is direction: one read, zero write.
// RL23 - Respond only when the upper four bits match the device type.
// RL24 - Programming lasts at most 6 ms from the stop; no response meanwhile.
// RL25 - Data pin only pulled low, released otherwise, also while programming.
// RL26 - A start mid-transaction aborts it, drops partial page data, restarts.
module tws_slave #(
    parameter logic [3:0] DEVICE_TYPE = 4'h5, // Arbitrary value
    parameter int TWR_CYCLES = tws_pkg::TWR_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Two-wire bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Strap and protect pins
    input wire logic [2:0] chip_select_straps,
    input wire logic write_protect,
    // Status
    output logic prog_busy
);

    localparam int TMR_W = $clog2(TWR_CYCLES + 1);
    localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(TWR_CYCLES - 1);

    // ----------------------------------------------------------------
    // Pin synchronisers and condition detection
    // ----------------------------------------------------------------
    logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p, wp_m, wp_s;
    logic [2:0] strap_m, strap_s;
    logic scl_rise, scl_fall, start_ev, stop_ev;

    // Two flops per pin, then one history flop on clock and data for edge finding
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_p <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_p <= 1'b1;
            wp_m <= 1'b0;
            wp_s <= 1'b0;
            strap_m <= 3'h0;
            strap_s <= 3'h0;
        end else begin
            scl_m <= scl_in;
            scl_s <= scl_m;
            scl_p <= scl_s;
            sda_m <= sda_in;
            sda_s <= sda_m;
            sda_p <= sda_s;
            wp_m <= write_protect;
            wp_s <= wp_m;
            strap_m <= chip_select_straps;
            strap_s <= strap_m;
        end
    end

    // Clock edges and high-phase data edges
    assign scl_rise = scl_s && !scl_p;
    assign scl_fall = !scl_s && scl_p;
    assign start_ev = scl_s && scl_p && sda_p && !sda_s; // RL3 RL4
    assign stop_ev = scl_s && scl_p && !sda_p && sda_s; // RL3 RL5

    // ----------------------------------------------------------------
    // Protocol state and shared strobes
    // ----------------------------------------------------------------
    tws_pkg::tws_state_t state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shreg_q, tx_q, fifo_head;
    logic [4:0] addr_hi_q;
    logic [12:0] addr_q, pf_addr_q;
    logic sda_oe_q, busy_q;
    logic byte_end, ack_end, dev_hit, wr_take, rd_pop, rd_go;
    logic [1:0] fifo_cnt_q;

    // Byte frame strobes and slave address decode
    assign byte_end = scl_fall && (bit_cnt_q == tws_pkg::BITS_DATA);
    assign ack_end = scl_fall && (bit_cnt_q == tws_pkg::BITS_ACK);
    assign dev_hit = (shreg_q[tws_pkg::TYPE_MSB:tws_pkg::TYPE_LSB] == DEVICE_TYPE) // RL23
        && (shreg_q[tws_pkg::SEL_MSB:tws_pkg::SEL_LSB] == strap_s) // RL1
        && !busy_q; // RL13
    assign wr_take = byte_end && (state_q == tws_pkg::TWS_WR) && !wp_s;
    assign rd_pop = ack_end && (state_q == tws_pkg::TWS_RD);
    assign rd_go = byte_end && (state_q == tws_pkg::TWS_DEV) && dev_hit
        && shreg_q[tws_pkg::DIR_BIT];

    // Transaction sequencer, acknowledge and transmit drive
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= tws_pkg::TWS_IDLE;
            bit_cnt_q <= 4'h0;
            shreg_q <= 8'h00;
            tx_q <= tws_pkg::IDLE_BYTE;
            addr_hi_q <= 5'h00;
            addr_q <= tws_pkg::ADDR_RST;
            sda_oe_q <= 1'b0;
        end else if (start_ev) begin
            state_q <= tws_pkg::TWS_DEV; // RL4 RL26
            bit_cnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
        end else if (stop_ev) begin
            state_q <= tws_pkg::TWS_IDLE; // RL5
            bit_cnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
        end else if (state_q == tws_pkg::TWS_IDLE) begin
            bit_cnt_q <= 4'h0; // RL4
        end else if (scl_rise && bit_cnt_q != tws_pkg::BITS_ACK) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q != tws_pkg::BITS_DATA) begin
                shreg_q <= {shreg_q[6:0], sda_s};
            end else if (state_q == tws_pkg::TWS_RD && sda_s) begin
                state_q <= tws_pkg::TWS_IGN; // RL17 RL19
            end
        end else if (byte_end) begin
            unique case (state_q)
                tws_pkg::TWS_DEV: begin
                    sda_oe_q <= dev_hit; // RL13 RL21
                    if (!dev_hit) begin
                        state_q <= tws_pkg::TWS_IGN;
                    end else if (shreg_q[tws_pkg::DIR_BIT]) begin
                        state_q <= tws_pkg::TWS_RD; // RL22
                    end else begin
                        state_q <= tws_pkg::TWS_AHI; // RL22
                    end
                end
                tws_pkg::TWS_AHI: begin
                    sda_oe_q <= 1'b1; // RL7 RL14
                    addr_hi_q <= shreg_q[tws_pkg::HI_USED_W-1:0]; // RL6
                    state_q <= tws_pkg::TWS_ALO;
                end
                tws_pkg::TWS_ALO: begin
                    sda_oe_q <= 1'b1; // RL7 RL14
                    addr_q <= {addr_hi_q, shreg_q}; // RL6 RL11
                    state_q <= tws_pkg::TWS_WR; // RL18
                end
                tws_pkg::TWS_WR: begin
                    if (wp_s) begin
                        state_q <= tws_pkg::TWS_IGN; // RL14
                    end else begin
                        sda_oe_q <= 1'b1; // RL7 RL12
                        addr_q[tws_pkg::PAGE_W-1:0] <=
                            addr_q[tws_pkg::PAGE_W-1:0] + 5'h01; // RL10 RL16
                    end
                end
                tws_pkg::TWS_RD: begin
                    sda_oe_q <= 1'b0; // RL21
                end
                tws_pkg::TWS_IDLE, tws_pkg::TWS_IGN: begin
                    sda_oe_q <= 1'b0; // RL25
                end
            endcase
        end else if (ack_end) begin
            bit_cnt_q <= 4'h0;
            if (state_q == tws_pkg::TWS_RD) begin
                tx_q <= (fifo_cnt_q != 2'h0) ? fifo_head : tws_pkg::IDLE_BYTE;
                sda_oe_q <= (fifo_cnt_q != 2'h0) ? !fifo_head[7] : 1'b0; // RL25
                addr_q <= addr_q + 13'h0001; // RL16 RL19 RL20
            end else begin
                sda_oe_q <= 1'b0; // RL21
            end
        end else if (scl_fall && state_q == tws_pkg::TWS_RD) begin
            sda_oe_q <= !tx_q[3'h7 - bit_cnt_q[2:0]]; // RL3 RL17 RL25
        end
    end

    // The pin is only ever pulled low
    assign sda_out = 1'b0; // RL25
    assign sda_oe = sda_oe_q;
    assign prog_busy = busy_q;

    // ----------------------------------------------------------------
    // Two-entry read prefetch buffer
    // ----------------------------------------------------------------
    logic [7:0] mem [2**tws_pkg::ADDR_W];
    logic [7:0] fifo_mem [2];
    logic fifo_wp_q, fifo_rp_q, fifo_flush, fifo_push, fifo_pop;

    // Fill side stalls while full; drain side takes a word per read byte
    assign fifo_flush = start_ev || stop_ev || rd_go;
    assign fifo_push = (state_q == tws_pkg::TWS_RD) && (fifo_cnt_q != 2'h2) && !fifo_flush;
    assign fifo_pop = rd_pop && (fifo_cnt_q != 2'h0);
    assign fifo_head = fifo_mem[fifo_rp_q];

    // Pointers, fill count and prefetch address
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            fifo_wp_q <= 1'b0;
            fifo_rp_q <= 1'b0;
            fifo_cnt_q <= 2'h0;
            pf_addr_q <= tws_pkg::ADDR_RST;
        end else if (fifo_flush) begin
            fifo_wp_q <= 1'b0;
            fifo_rp_q <= 1'b0;
            fifo_cnt_q <= 2'h0;
            if (rd_go) begin
                pf_addr_q <= addr_q; // RL16 RL17
            end
        end else begin
            if (fifo_push) begin
                fifo_wp_q <= !fifo_wp_q;
                pf_addr_q <= pf_addr_q + 13'h0001; // RL20
            end
            if (fifo_pop) begin
                fifo_rp_q <= !fifo_rp_q;
            end
            fifo_cnt_q <= fifo_cnt_q + {1'b0, fifo_push} - {1'b0, fifo_pop};
        end
    end

    // Buffer storage
    always_ff @(posedge clock) begin
        if (fifo_push) begin
            fifo_mem[fifo_wp_q] <= mem[pf_addr_q];
        end
    end

    // ----------------------------------------------------------------
    // Page buffer and self-timed programming
    // ----------------------------------------------------------------
    logic [7:0] pbuf [tws_pkg::PAGE_BYTES];
    logic [tws_pkg::PAGE_BYTES-1:0] pvalid_q;
    logic [7:0] prog_page_q;
    logic [5:0] prog_idx_q;
    logic [TMR_W-1:0] tmr_q;
    logic prog_go, prog_done;

    // Stop after accepted data bytes launches the cycle
    assign prog_go = stop_ev && (state_q == tws_pkg::TWS_WR) && (|pvalid_q) && !busy_q; // RL8
    assign prog_done = busy_q && (tmr_q == '0);

    // Page data capture, wrap overwrite and discard
    always_ff @(posedge clock) begin
        if (wr_take) begin
            pbuf[addr_q[tws_pkg::PAGE_W-1:0]] <= shreg_q; // RL9 RL12
        end
    end

    // Per-byte loaded flags
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pvalid_q <= '0;
        end else if (prog_done || (start_ev && !busy_q)) begin
            pvalid_q <= '0; // RL26
        end else if (byte_end && state_q == tws_pkg::TWS_ALO) begin
            pvalid_q <= '0;
        end else if (wr_take) begin
            pvalid_q[addr_q[tws_pkg::PAGE_W-1:0]] <= 1'b1; // RL11 RL12
        end
    end

    // Programming timer and copy index
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            busy_q <= 1'b0;
            tmr_q <= '0;
            prog_idx_q <= 6'h00;
            prog_page_q <= 8'h00;
        end else if (prog_go) begin
            busy_q <= 1'b1; // RL8
            tmr_q <= TMR_LOAD; // RL24
            prog_idx_q <= 6'h00;
            prog_page_q <= addr_q[tws_pkg::ADDR_W-1:tws_pkg::PAGE_W]; // RL9
        end else if (busy_q) begin
            if (!prog_idx_q[5]) begin
                prog_idx_q <= prog_idx_q + 6'h01;
            end
            if (prog_done) begin
                busy_q <= 1'b0; // RL13 RL24
            end else begin
                tmr_q <= tmr_q - TMR_W'(1);
            end
        end
    end

    // Array write, one page byte per cycle
    always_ff @(posedge clock) begin
        if (busy_q && !prog_idx_q[5] && pvalid_q[prog_idx_q[4:0]]) begin
            mem[{prog_page_q, prog_idx_q[4:0]}] <= pbuf[prog_idx_q[4:0]]; // RL9
        end
    end

    // ----------------------------------------------------------------
    // Assertions and covers
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    // The drive moves one edge after its cause, so the cause is looked up one cycle back
    a_oe_clock_low: assert property ($changed(sda_oe_q)
        |-> !$past(scl_s) || $past(start_ev) || $past(stop_ev)) // RL3
        else $error("data drive changed with clock high");
    a_strap_mismatch: assert property (byte_end && state_q == tws_pkg::TWS_DEV
        && shreg_q[3:1] != strap_s |=> !sda_oe_q && state_q == tws_pkg::TWS_IGN) // RL1
        else $error("acknowledged a foreign selection field");
    a_type_mismatch: assert property (byte_end && state_q == tws_pkg::TWS_DEV
        && shreg_q[7:4] != DEVICE_TYPE |=> !sda_oe_q) // RL23
        else $error("acknowledged a foreign device type");
    a_busy_no_ack: assert property (busy_q && byte_end && state_q == tws_pkg::TWS_DEV
        |=> (!sda_oe_q)[*4]) // RL8 RL13
        else $error("acknowledged while programming");
    a_wp_refuse: assert property (byte_end && state_q == tws_pkg::TWS_WR && wp_s
        |=> !sda_oe_q && state_q == tws_pkg::TWS_IGN) // RL14
        else $error("data acknowledged under write protect");
    a_page_wrap: assert property (wr_take |=> addr_q[12:5] == $past(addr_q[12:5])
        && addr_q[4:0] == $past(addr_q[4:0]) + 5'h01) // RL10 RL12
        else $error("write counter left its page");
    a_read_incr: assert property (rd_pop |=> addr_q == $past(addr_q) + 13'h0001) // RL20
        else $error("read counter did not advance");
    a_stop_idle: assert property (stop_ev |=> state_q == tws_pkg::TWS_IDLE && !sda_oe_q) // RL5
        else $error("stop did not return to standby");
    a_start_restart: assert property (start_ev |=> state_q == tws_pkg::TWS_DEV
        && bit_cnt_q == 4'h0 && (busy_q || pvalid_q == '0)) // RL4 RL26
        else $error("start did not restart address reception");
    a_prog_launch: assert property (prog_go |=> busy_q && tmr_q == TMR_LOAD) // RL8 RL24
        else $error("programming not launched at stop");
    // Timer counts down by one each busy cycle, never above its load value
    a_prog_bound: assert property (busy_q && tmr_q != '0 |=> busy_q && tmr_q <= TMR_LOAD
        && tmr_q == $past(tmr_q) - TMR_W'(1)) // RL24
        else $error("programming timer beyond limit");

    c_byte_prog: cover property (prog_go ##1 busy_q);
    c_read_byte: cover property (rd_pop && fifo_cnt_q != 2'h0);
    c_poll_nack: cover property (busy_q && byte_end && state_q == tws_pkg::TWS_DEV);
    c_seq_read: cover property (rd_pop ##[1:200] rd_pop);

endmodule // tws_slave

/* File: dv/tws_master.sv */
// Behavioural two-wire bus master that drives the slave under test
`timescale 1ns/1ps
module tws_master (
    // Clock
    input wire logic clock,
    // Bus wires
    output logic scl,
    output logic sda,
    // Slave drive
    input wire logic sda_out,
    input wire logic sda_oe
);
    logic sda_m = 1'b1; // Own open-drain drive, high means released
    int slow = 0; // Extra low-phase cycles, stalls the slave

    // Wired-AND with a pull-up, so a released wire reads high
    assign sda = sda_m & (sda_oe ? sda_out : 1'b1);

    // Clock stands high between frames
    initial begin
        scl = 1'b1;
    end

    // -------------------------------------------------------------
    // Bit level
    // -------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Data moves only while the clock is low; only we drive the clock
    task automatic bit_out(input logic b);
        tick(2);
        sda_m = b;
        tick(2 + slow);
        scl = 1'b1;
        tick(4);
        scl = 1'b0;
    endtask

    // Release the wire and sample it in the high phase
    task automatic bit_in(output logic b);
        tick(1);
        sda_m = 1'b1;
        tick(3 + slow);
        scl = 1'b1;
        tick(2);
        b = sda;
        tick(2);
        scl = 1'b0;
    endtask

    // Start, also as a repeated start from a low clock
    task automatic start();
        tick(1);
        sda_m = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_m = 1'b0;
        tick(4);
        scl = 1'b0;
    endtask

    // Stop leaves both wires high and the clock still
    task automatic stop();
        tick(2);
        sda_m = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_m = 1'b1;
        tick(4);
    endtask

    // -------------------------------------------------------------
    // Byte level, most significant bit first
    // -------------------------------------------------------------
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_out(d[i]);
        end
        bit_in(b);
        ack = ~b;
    endtask

    task automatic recv_byte(output logic [7:0] d, input logic more);
        for (int i = 7; i >= 0; i--) begin
            bit_in(d[i]);
        end
        bit_out(~more);
    endtask
endmodule // tws_master

/* File: dv/testbench.sv */
// Self-checking testbench for the two-wire serial memory slave
`timescale 1ns/1ps
module testbench;
    localparam logic [3:0] DEV_TYPE = 4'h6; // Arbitrary device type value
    localparam logic [2:0] STRAPS = 3'h5;
    localparam int TWR = 400;

    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] straps = STRAPS;
    logic wp = 1'b0;
    wire scl;
    wire sda;
    logic sda_out;
    logic sda_oe;
    logic prog_busy;
    logic [7:0] mem [0:8191];
    logic [12:0] cur;
    int fails = 0;
    int n_checks = 0;
    int busy_len = 0;

    tws_slave #(.DEVICE_TYPE(DEV_TYPE), .TWR_CYCLES(TWR)) u_tws_slave (
        .clock(clock), .reset_n(reset_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .chip_select_straps(straps), .write_protect(wp),
        .prog_busy(prog_busy));
    tws_master u_tws_master (
        .clock(clock), .scl(scl), .sda(sda), .sda_out(sda_out), .sda_oe(sda_oe));

    // 40 MHz clock
    initial begin
        forever #12.5 clock = ~clock;
    end

    // Length of the current programming cycle in clocks, cleared one clock after it ends
    always @(posedge clock) begin
        if (prog_busy === 1'b1) begin
            busy_len <= busy_len + 1;
        end else begin
            busy_len <= 0;
        end
    end

    // -------------------------------------------------------------
    // Checking and access tasks
    // -------------------------------------------------------------
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_b(input logic got, input logic exp);
        chk({7'h0, got}, {7'h0, exp});
    endtask

    task automatic head(input logic rd, input logic [3:0] ty, input logic [2:0] sel,
                        output logic ack);
        u_tws_master.start();
        u_tws_master.send_byte({ty, sel, rd}, ack);
    endtask

    // Write header and location; junk fills the unused top bits
    task automatic set_addr(input logic [12:0] a, input logic [2:0] junk);
        logic ack;
        head(1'b0, DEV_TYPE, STRAPS, ack);
        chk_b(ack, 1'b1);
        u_tws_master.send_byte({junk, a[12:8]}, ack);
        chk_b(ack, 1'b1);
        u_tws_master.send_byte(a[7:0], ack);
        chk_b(ack, 1'b1);
        cur = a;
    endtask

    // Busy after the stop, nack while busy, ack once done
    task automatic wait_prog();
        logic ack;
        int k;
        k = 0;
        while (prog_busy !== 1'b1 && k < 10) begin
            u_tws_master.tick(1);
            k++;
        end
        chk_b(prog_busy, 1'b1);
        head(1'b0, DEV_TYPE, STRAPS, ack);
        chk_b(ack, 1'b0);
        chk_b(sda_oe, 1'b0);
        u_tws_master.stop();
        k = 0;
        while (prog_busy === 1'b1 && k < TWR + 10) begin
            u_tws_master.tick(1);
            k++;
        end
        chk_b(k < TWR, 1'b1);
        chk_b(busy_len == TWR, 1'b1);
        head(1'b0, DEV_TYPE, STRAPS, ack);
        chk_b(ack, 1'b1);
        u_tws_master.stop();
    endtask

    task automatic write(input logic [12:0] a, input int n, input logic [7:0] seed);
        logic ack;
        set_addr(a, 3'h0);
        for (int i = 0; i < n; i++) begin
            u_tws_master.send_byte(seed + 8'(i), ack);
            chk_b(ack, 1'b1);
            mem[cur] = seed + 8'(i);
            cur = {cur[12:5], cur[4:0] + 5'h1};
        end
        u_tws_master.stop();
        wait_prog();
    endtask

    task automatic read(input int n);
        logic ack;
        logic [7:0] d;
        head(1'b1, DEV_TYPE, STRAPS, ack);
        chk_b(ack, 1'b1);
        for (int i = 0; i < n; i++) begin
            u_tws_master.recv_byte(d, i < n - 1);
            chk(d, mem[cur]);
            cur = cur + 13'h1;
        end
        u_tws_master.stop();
    endtask

    // -------------------------------------------------------------
    // Tests
    // -------------------------------------------------------------
    initial begin
        logic ack;
        u_tws_master.tick(4);
        reset_n = 1'b1;
        u_tws_master.tick(4);
        chk_b(sda_oe, 1'b0);
        chk_b(prog_busy, 1'b0);
        for (int i = 0; i < 4; i++) begin
            head(1'b0, (i == 3) ? ~DEV_TYPE : DEV_TYPE,
                 (i == 3) ? STRAPS : STRAPS ^ (3'h1 << i), ack);
            chk_b(ack, 1'b0);
            u_tws_master.stop();
        end
        $display("test refusal done");
        write(13'h0005, 34, 8'h10);
        u_tws_master.slow = 12;
        write(13'h1ffd, 5, 8'h80);
        write(13'h0002, 1, 8'h5a);
        $display("test write done");
        set_addr(13'h1ffe, 3'h7);
        read(5);
        read(1);
        $display("test read done");
        wp = 1'b1;
        set_addr(13'h0003, 3'h0);
        u_tws_master.send_byte(8'hee, ack);
        chk_b(ack, 1'b0);
        u_tws_master.stop();
        u_tws_master.tick(20);
        chk_b(prog_busy, 1'b0);
        wp = 1'b0;
        set_addr(13'h0003, 3'h0);
        read(1);
        $display("test protect done");
        set_addr(13'h0010, 3'h0);
        u_tws_master.send_byte(8'hc1, ack);
        chk_b(ack, 1'b1);
        set_addr(13'h0010, 3'h0);
        read(2);
        chk_b(prog_busy, 1'b0);
        $display("test abort done");
        close_out();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (60000) @(posedge clock);
        fails++;
        close_out();
    end
endmodule // testbench
